// ---- inc/smm_cfg.svh ----
// Constants of the slicer mean-square monitor.
`ifndef SMM_CFG_SVH
`define SMM_CFG_SVH
`define SMM_REF_HI        9'sd128
`define SMM_REF_MID       9'sd64
`define SMM_THR_3_HI      9'sd64
`define SMM_THR_5_HI      9'sd96
`define SMM_THR_5_LO      9'sd32
`define SMM_ERR_MAX_1G    7'd32
`define SMM_ERR_MAX_100M  7'd64
`define SMM_RESULT_MAX    9'h1FF
`define SMM_SAVE_TIME_US  1000
`define SMM_SYMBOL_NS     8
`define SMM_SAVE_SYMBOLS  ((`SMM_SAVE_TIME_US * 1000) / `SMM_SYMBOL_NS)
`define SMM_PAIRS         4
`define SMM_ACC_W         24
`endif

// ---- inc/smm_pkg.sv ----
// Types of the slicer mean-square monitor.
package smm_pkg;
    typedef logic [23:0] smm_acc_t;
    typedef logic [8:0]  smm_result_t;
    typedef logic [1:0]  smm_pair_t;
endpackage

// ---- rtl/smm_pair_filter.sv ----
// One per-pair low-pass filter of the slicer error.
`timescale 1ns/1ps
`default_nettype none
`include "smm_cfg.svh"
module smm_pair_filter (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic             sample_valid,
    input  wire logic [13:0]      err_term,
    input  wire logic [3:0]       filter_shift_factor,
    output logic [23:0]           filt_value
);
    typedef struct packed {
        logic [23:0] acc;
    } smm_pf_state_t;

    smm_pf_state_t st_reg;
    smm_pf_state_t st_next;

    logic signed [25:0] diff;

    always_comb begin
        st_next = st_reg;
        diff = $signed({12'h000, err_term}) - $signed({2'b00, st_reg.acc});
        if (sample_valid) begin
            // Arithmetic shift keeps the decay symmetric for a falling error.
            st_next.acc = 24'(st_reg.acc + 24'(diff >>> filter_shift_factor));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign filt_value = st_reg.acc;
endmodule
`default_nettype wire

// ---- rtl/smm_monitor.sv ----
// Slicer mean-square error monitor, top level.
`timescale 1ns/1ps
`default_nettype none
`include "smm_cfg.svh"
// Function
// - Ideal levels are -128,0,128 (three-level) and -128,-64,0,64,128 (five-level).
// - Decisions use thresholds +/-64 (three-level) and +/-32,+/-96 (five-level).
// - The slicer error magnitude is limited to 32 in gigabit and 64 in 100 Mb/s mode.
// - Nothing is measured unless the measurement enable is set.
// - Each sample adds a weighted difference of the (doubled in gigabit) error and the state.
// - The add-back term is divided by two to the filter shift factor.
// - The filtered value is divided by two to the output shift to give 0..511.
// - A value that does not fit saturates at 511.
// - A snapshot request with a pair number self-clears and loads that pair's result.
// - The filtered value is saved for capture every 125000 symbols.
// - A worst-case value holds the highest result since the result was last read.
module smm_monitor (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic                clk_en,
    input  wire logic                sample_valid,
    input  wire logic [1:0]          sample_pair,
    input  wire logic signed [8:0]   sample_value,
    input  wire logic                gigabit_mode,
    input  wire logic                measure_enable,
    input  wire logic                square_mode,
    input  wire logic [3:0]          filter_shift_factor,
    input  wire logic [4:0]          mse_output_shift,
    input  wire logic                snapshot_request,
    input  wire logic [1:0]          cable_pair_select,
    input  wire logic                result_read,
    output logic                     snapshot_busy,
    output logic [8:0]               mean_square_result,
    output logic [8:0]               mean_square_worst
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [16:0]     save_cnt;
        smm_pkg::smm_acc_t [3:0] saved;
        logic            snap_pend;
        smm_pkg::smm_pair_t snap_pair;
        smm_pkg::smm_result_t result;
        smm_pkg::smm_result_t worst;
        logic            worst_restart;
    } smm_state_t;

    smm_state_t st_reg;
    smm_state_t st_next;

    // Every state flop leaves reset on the same edge, whatever the phase of the release.
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------
    // Slicer
    // ------------------------------------------------------------
    logic signed [8:0] ideal;
    logic signed [9:0] err_s;
    logic [7:0]        err_abs;
    logic [6:0]        err_lim;
    logic [6:0]        err_scaled;
    logic [13:0]       err_term;

    always_comb begin
        if (gigabit_mode) begin
            if (sample_value > `SMM_THR_5_HI) begin
                ideal = `SMM_REF_HI;
            end else if (sample_value > `SMM_THR_5_LO) begin
                ideal = `SMM_REF_MID;
            end else if (sample_value >= -`SMM_THR_5_LO) begin
                ideal = 9'sd0;
            end else if (sample_value >= -`SMM_THR_5_HI) begin
                ideal = -`SMM_REF_MID;
            end else begin
                ideal = -`SMM_REF_HI;
            end
        end else begin
            if (sample_value > `SMM_THR_3_HI) begin
                ideal = `SMM_REF_HI;
            end else if (sample_value >= -`SMM_THR_3_HI) begin
                ideal = 9'sd0;
            end else begin
                ideal = -`SMM_REF_HI;
            end
        end
    end

    // ------------------------------------------------------------
    // Slicer error
    // ------------------------------------------------------------
    // The magnitude needs eight bits: a sample at the negative rail sits 128 below its level.
    always_comb begin
        err_s = 10'(sample_value) - 10'(ideal);
        err_abs = err_s[9] ? 8'(-err_s) : 8'(err_s);
        // Samples beyond the outer levels are clipped to the documented bound.
        if (gigabit_mode) begin
            if (err_abs > 8'(`SMM_ERR_MAX_1G)) begin
                err_lim = `SMM_ERR_MAX_1G;
            end else begin
                err_lim = err_abs[6:0];
            end
            err_scaled = 7'(err_lim << 1);
        end else begin
            if (err_abs > 8'(`SMM_ERR_MAX_100M)) begin
                err_lim = `SMM_ERR_MAX_100M;
            end else begin
                err_lim = err_abs[6:0];
            end
            err_scaled = err_lim;
        end
        // Both factors are widened first, so the product is not cut to seven bits.
        // Square mode is software's choice; without it the mean absolute error is filtered.
        err_term = square_mode ? 14'(err_scaled) * 14'(err_scaled) : {7'h00, err_scaled};
    end

    // ------------------------------------------------------------
    // Per-pair filters
    // ------------------------------------------------------------
    logic [23:0] filt [4];

    for (genvar p = 0; p < `SMM_PAIRS; p++) begin : g_pair
        smm_pair_filter u_filt (
            .ref_clk             (ref_clk),
            .rst_n               (rst_n),
            .clk_en              (clk_en),
            .sample_valid        (sample_valid && measure_enable && sample_pair == 2'(p)),
            .err_term            (err_term),
            .filter_shift_factor (filter_shift_factor),
            .filt_value          (filt[p])
        );
    end

    // ------------------------------------------------------------
    // Save, capture and worst case
    // ------------------------------------------------------------
    // A capture reads the last saved value, not the live filter, so a result can be up to
    // one save period old; the trade buys a stable value across the four pairs.
    logic [23:0] scaled;
    logic [8:0]  capped;

    always_comb begin
        st_next = st_reg;
        scaled = st_reg.saved[st_reg.snap_pair] >> mse_output_shift;
        capped = (scaled > 24'(`SMM_RESULT_MAX)) ? `SMM_RESULT_MAX : scaled[8:0];
        if (measure_enable) begin
            if (st_reg.save_cnt == 17'(`SMM_SAVE_SYMBOLS - 1)) begin
                st_next.save_cnt = 17'h00000;
                for (int i = 0; i < `SMM_PAIRS; i++) begin
                    st_next.saved[i] = filt[i];
                end
            end else begin
                st_next.save_cnt = st_reg.save_cnt + 17'h00001;
            end
        end
        if (result_read) begin
            st_next.worst_restart = 1'b1;
        end
        st_next.snap_pend = 1'b0;
        if (st_reg.snap_pend) begin
            st_next.result = capped;
            // A read in the same cycle sets the restart again, so the next capture replaces this value as the baseline.
            if (st_reg.worst_restart || capped > st_reg.worst) begin
                st_next.worst = capped;
            end
            st_next.worst_restart = result_read;
        end
        if (snapshot_request) begin
            st_next.snap_pend = 1'b1;
            st_next.snap_pair = cable_pair_select;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign snapshot_busy      = st_reg.snap_pend;
    assign mean_square_result = st_reg.result;
    assign mean_square_worst  = st_reg.worst;
endmodule
`default_nettype wire

// ---- dv/smm_monitor_assertions.sv ----
// Port-level checks of the slicer mean-square monitor capture path.
`timescale 1ns/1ps
`default_nettype none
module smm_monitor_assertions (
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic       clk_en,
    input wire logic       snapshot_request,
    input wire logic       snapshot_busy,
    input wire logic [8:0] mean_square_result,
    input wire logic [8:0] mean_square_worst
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_busy_after_req: assert property (snapshot_request && clk_en |=> snapshot_busy)
        else $error("busy missing after capture request");
    a_busy_has_cause: assert property (snapshot_busy |-> $past(snapshot_request))
        else $error("busy without a request");
    a_busy_one_cycle: assert property (snapshot_busy && !snapshot_request |=> !snapshot_busy)
        else $error("busy stood longer than one cycle");
    a_result_on_cap: assert property ($changed(mean_square_result) |-> $past(snapshot_busy))
        else $error("result moved without a capture");
    a_result_holds: assert property (!snapshot_busy [*2] |-> $stable(mean_square_result))
        else $error("result not held between captures");
    a_worst_on_cap: assert property ($changed(mean_square_worst) |-> $past(snapshot_busy))
        else $error("worst moved without a capture");
    a_worst_above: assert property ($past(snapshot_busy) |-> mean_square_worst >= mean_square_result)
        else $error("worst below current result");
    a_worst_restart: assert property (mean_square_worst < $past(mean_square_worst)
        |-> mean_square_worst == mean_square_result)
        else $error("worst dropped to a value other than the result");
endmodule
bind smm_monitor smm_monitor_assertions u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .snapshot_request(snapshot_request),
    .snapshot_busy(snapshot_busy), .mean_square_result(mean_square_result),
    .mean_square_worst(mean_square_worst));
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking testbench of the slicer mean-square monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic              ref_clk = 0, resetn = 0, sample_valid = 0, gigabit_mode = 0;
    logic              measure_enable = 0, square_mode = 0, snapshot_request = 0, result_read = 0;
    logic              clk_en = 1;
    logic        [1:0] sample_pair = 0, cable_pair_select = 0;
    logic signed [8:0] sample_value = 0;
    logic        [3:0] filter_shift_factor = 0;
    logic        [4:0] mse_output_shift = 0;
    logic              snapshot_busy;
    logic        [8:0] mean_square_result, mean_square_worst;
    int                err_count = 0, total_checks = 0;
    smm_monitor uut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
        .sample_valid(sample_valid), .sample_pair(sample_pair), .sample_value(sample_value),
        .gigabit_mode(gigabit_mode), .measure_enable(measure_enable), .square_mode(square_mode),
        .filter_shift_factor(filter_shift_factor), .mse_output_shift(mse_output_shift),
        .snapshot_request(snapshot_request), .cable_pair_select(cable_pair_select),
        .result_read(result_read), .snapshot_busy(snapshot_busy),
        .mean_square_result(mean_square_result), .mean_square_worst(mean_square_worst));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task check(input string n, input logic [8:0] s, input logic [8:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, s);
        end
    endtask
    task send(input logic [1:0] p, input logic signed [8:0] v, input logic g, input logic sq,
              input logic [3:0] k);
        @(negedge ref_clk);
        {sample_pair, sample_value, gigabit_mode, square_mode} = {p, v, g, sq};
        filter_shift_factor = k;
        sample_valid = 1;
        @(negedge ref_clk);
        sample_valid = 0;
    endtask
    // Busy is looked at in the cycle after the request, the results one cycle later.
    task cap(input logic [1:0] p, input logic [4:0] sh, input logic [8:0] er, input logic [8:0] ew);
        @(negedge ref_clk);
        {cable_pair_select, mse_output_shift, snapshot_request} = {p, sh, 1'b1};
        @(negedge ref_clk);
        snapshot_request = 0;
        check("busy", snapshot_busy, 1);
        @(negedge ref_clk);
        check("busy", snapshot_busy, 0);
        check("result", mean_square_result, er);
        check("worst", mean_square_worst, ew);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge ref_clk);
        resetn = 1;
        repeat (4) @(negedge ref_clk);
        check("reset result", mean_square_result, 0);
        check("reset worst", mean_square_worst, 0);
        measure_enable = 1;
        send(2'h1, 9'sh064, 0, 0, 4'h0);
        send(2'h1, 9'sh080, 0, 0, 4'h1);
        send(2'h2, 9'sh0FF, 0, 0, 4'h0);
        send(2'h0, -9'sd45, 1, 0, 4'h0);
        send(2'h3, 9'sh014, 1, 1, 4'h0);
        measure_enable = 0;
        send(2'h1, 9'sh0FF, 0, 0, 4'h1);
        measure_enable = 1;
        // A sample offered while the clock enable is low must leave pair 1 at its value.
        clk_en = 0;
        send(2'h1, 9'sh0FF, 0, 0, 4'h0);
        clk_en = 1;
        $display("filter stimulus done");
        repeat (125010) @(negedge ref_clk);
        cap(2'h1, 5'h00, 9'h00E, 9'h00E);
        cap(2'h2, 5'h00, 9'h040, 9'h040);
        cap(2'h0, 5'h00, 9'h026, 9'h040);
        @(negedge ref_clk);
        result_read = 1;
        @(negedge ref_clk);
        result_read = 0;
        cap(2'h1, 5'h00, 9'h00E, 9'h00E);
        cap(2'h3, 5'h02, 9'h190, 9'h190);
        cap(2'h3, 5'h00, 9'h1FF, 9'h1FF);
        $display("capture sequence done");
        finish_test();
    end
endmodule
`default_nettype wire
